/* common/sgc_pkg.sv */
package sgc_pkg;

  // register map
  localparam logic [3:0] SGC_REG_CTRL   = 4'h0;
  localparam logic [3:0] SGC_REG_STATUS = 4'h1;
  localparam logic [7:0] SGC_CTRL_RESET = 8'h00;
  localparam logic [7:0] SGC_RD_NONE    = 8'h00;

  // control register fields
  localparam int SGC_CTRL_BURST    = 0;
  localparam int SGC_CTRL_LEVEL    = 1;
  localparam int SGC_CTRL_POLARITY = 2;

  // status register fields
  localparam int SGC_ST_STOP_GO = 0;
  localparam int SGC_ST_DBLOCK  = 1;
  localparam int SGC_ST_BAC     = 2;
  localparam int SGC_ST_LATCHED = 3;
  localparam int SGC_ST_PULSE   = 4;
  localparam int SGC_ST_SHORT   = 5;
  localparam int SGC_ST_DELAY   = 6;

  // operations-channel codes
  localparam logic [7:0] SGC_EOC_STOP = 8'h25;
  localparam logic [7:0] SGC_EOC_GO   = 8'h27;

  // serial bus framing
  localparam logic [7:0] SGC_SG_BIT_NUM  = 8'h1b;
  localparam logic [7:0] SGC_BIT_CTR_RST = 8'h00;
  localparam logic [2:0] SGC_PULSE_FRAMES = 3'h4;
  localparam logic [2:0] SGC_PULSE_LAST   = 3'h1;

  // timing
  localparam int SGC_CLK_KHZ       = 40000;
  localparam int SGC_SHORT_US      = 500;
  localparam int SGC_DELAY_MIN_US  = 7500;
  localparam int SGC_DELAY_STEP_US = 500;
  localparam int SGC_SHORT_CYC      = SGC_SHORT_US * SGC_CLK_KHZ / 1000;
  localparam int SGC_DELAY_MIN_CYC  = SGC_DELAY_MIN_US * SGC_CLK_KHZ / 1000;
  localparam int SGC_DELAY_STEP_CYC = SGC_DELAY_STEP_US * SGC_CLK_KHZ / 1000;
  localparam int SGC_TMR_W = 20;

  typedef enum logic [1:0] {
    SGC_IDLE,
    SGC_ARMED,
    SGC_PULSE
  } sgc_pulse_state_t;

endpackage : sgc_pkg

/* hw/sgc_timer.sv */
`timescale 1ns/100ps
module sgc_timer
  import sgc_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 start,
  input  wire logic [SGC_TMR_W-1:0] load,
  output logic                      running,
  output logic                      expired
);

  logic [SGC_TMR_W-1:0] count;
  wire                  last = running && (count == '0);

  // start restarts a running timer
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= last && !start;
      if (start)
      begin
        count   <= load - 1'b1;
        running <= 1'b1;
      end
      else if (last)
        running <= 1'b0;
      else if (running)
        count <= count - 1'b1;
    end
  end

endmodule : sgc_timer

/* hw/sgc_stop_go_ctrl.sv */
`timescale 1ns/100ps
module sgc_stop_go_ctrl
  import sgc_pkg::*;
#(
  parameter int SHORT_CYC      = SGC_SHORT_CYC,
  parameter int DELAY_MIN_CYC  = SGC_DELAY_MIN_CYC,
  parameter int DELAY_STEP_CYC = SGC_DELAY_STEP_CYC
)
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       processor_mode_input,
  input  wire logic       terminal_mode_input,
  input  wire logic       receiver_synchronised,
  input  wire logic [7:0] eoc_code,
  input  wire logic       eoc_valid,
  input  wire logic [3:0] eoc_frame_pos,
  input  wire logic       bus_fsc,
  input  wire logic       bus_dcl,
  input  wire logic       bus_din,
  output logic            bus_dout,
  output logic            bus_dout_oe_n,
  input  wire logic       d_up_in,
  output logic            d_up_out,
  output logic            stop_go_output,
  output logic            d_channel_block
);

  logic [7:0]       ctrl;
  logic [2:0]       fsc_s;
  logic [2:0]       dcl_s;
  logic [1:0]       din_s;
  logic [1:0]       processor_mode_input_s;
  logic [7:0]       bit_ctr;
  logic [7:0]       cur_bit;
  logic             bac;
  logic             latched;
  logic             eoc_stop;
  logic             eoc_go;
  logic             sync_q;
  logic [2:0]       pulse_left;
  sgc_pulse_state_t pstate;
  sgc_pulse_state_t next_pstate;
  logic             short_run;
  logic             delay_run;
  logic             delay_exp;

  // control bits
  wire burst_select    = ctrl[SGC_CTRL_BURST];
  wire level_select    = ctrl[SGC_CTRL_LEVEL];
  wire polarity_select = ctrl[SGC_CTRL_POLARITY];

  // link edges, taken only from the second and third stages
  wire frame_start = fsc_s[1] && !fsc_s[2];
  wire dcl_rise    = dcl_s[1] && !dcl_s[2];
  wire dcl_fall    = !dcl_s[1] && dcl_s[2];
  wire din_q       = din_s[1];

  wire enabled     = processor_mode_input_s[1] && terminal_mode_input;
  wire mode_pulse  = burst_select && !level_select;
  wire mode_latch  = level_select && (burst_select || polarity_select);
  wire bac_rules   = level_select && polarity_select;
  wire stop_ok     = enabled && receiver_synchronised && eoc_stop;
  wire go_ok       = enabled && receiver_synchronised && eoc_go;
  wire pulse_start = stop_ok && mode_pulse && !short_run;
  wire pulse_on    = (pstate == SGC_PULSE);

  wire [SGC_TMR_W-1:0] short_load = SGC_TMR_W'(SHORT_CYC);
  wire [SGC_TMR_W-1:0] delay_load = SGC_TMR_W'(DELAY_MIN_CYC + eoc_frame_pos * DELAY_STEP_CYC);
  wire                 delay_start = mode_latch && latched && sync_q && !receiver_synchronised;

  wire reg_hit_ctrl   = (reg_addr == SGC_REG_CTRL);
  wire reg_hit_status = (reg_addr == SGC_REG_STATUS);
  wire [7:0] status_word = {1'b0, delay_run, short_run, pulse_on, latched, bac,
                            d_channel_block, stop_go_output};
  wire [7:0] next_rdata  = reg_hit_ctrl   ? ctrl :
                           reg_hit_status ? status_word : SGC_RD_NONE;

  // stop/go value per mode
  wire next_sg =
    !enabled                                            ? 1'b0 :
    (!burst_select && !level_select)                    ? 1'b0 :
    (!burst_select && level_select && !polarity_select) ? 1'b1 :
    mode_pulse                                          ? (pulse_on ^ polarity_select) :
    bac_rules                                           ? (latched || !bac) :
                                                          latched;
  wire next_block = enabled && burst_select && bac_rules && !bac;

  sgc_timer u_short_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (pulse_start),
    .load    (short_load),
    .running (short_run),
    .expired ()
  );

  sgc_timer u_frame_delay_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (delay_start),
    .load    (delay_load),
    .running (delay_run),
    .expired (delay_exp)
  );

  // register port
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl      <= SGC_CTRL_RESET;
      reg_rdata <= SGC_RD_NONE;
    end
    else
    begin
      if (reg_wr && reg_hit_ctrl)
        ctrl <= reg_wdata;
      reg_rdata <= reg_rd ? next_rdata : SGC_RD_NONE;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fsc_s   <= '0;
      dcl_s   <= '0;
      din_s   <= '1;
      processor_mode_input_s <= '0;
    end
    else
    begin
      fsc_s   <= {fsc_s[1:0], bus_fsc};
      dcl_s   <= {dcl_s[1:0], bus_dcl};
      din_s   <= {din_s[0], bus_din};
      processor_mode_input_s <= {processor_mode_input_s[0], processor_mode_input};
    end
  end

  // operations-channel code decode
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      eoc_stop <= 1'b0;
      eoc_go   <= 1'b0;
      sync_q   <= 1'b0;
    end
    else
    begin
      eoc_stop <= eoc_valid && (eoc_code == SGC_EOC_STOP);
      eoc_go   <= eoc_valid && (eoc_code == SGC_EOC_GO);
      sync_q   <= receiver_synchronised;
    end
  end

  // bit position in the frame, access bit and outgoing stop/go bit
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_ctr       <= SGC_BIT_CTR_RST;
      cur_bit       <= SGC_BIT_CTR_RST;
      bac           <= 1'b1;
      bus_dout      <= 1'b1;
      bus_dout_oe_n <= 1'b1;
    end
    else
    begin
      if (frame_start)
        bit_ctr <= SGC_BIT_CTR_RST;
      else if (dcl_rise)
      begin
        bit_ctr       <= bit_ctr + 8'h01;
        cur_bit       <= bit_ctr;
        bus_dout_oe_n <= (bit_ctr != SGC_SG_BIT_NUM);
        bus_dout      <= (bit_ctr == SGC_SG_BIT_NUM) ? stop_go_output : 1'b1;
      end
      if (dcl_fall && cur_bit == SGC_SG_BIT_NUM)
        bac <= din_q;
    end
  end

  // level latch for stop and go
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      latched <= 1'b0;
    else if (!enabled || !mode_latch)
      latched <= 1'b0;
    else if (stop_ok)
      latched <= 1'b1;
    else if (go_ok || (delay_exp && !receiver_synchronised))
      latched <= 1'b0;
  end

  // four-frame pulse
  always_comb
  begin
    next_pstate = pstate;
    case (pstate)
      SGC_IDLE:  if (pulse_start) next_pstate = SGC_ARMED;
      SGC_ARMED: if (frame_start) next_pstate = SGC_PULSE;
      SGC_PULSE: if (frame_start && pulse_left == SGC_PULSE_LAST) next_pstate = SGC_IDLE;
      default:   next_pstate = SGC_IDLE;
    endcase
    if (!enabled || !mode_pulse)
      next_pstate = SGC_IDLE;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pstate     <= SGC_IDLE;
      pulse_left <= '0;
    end
    else
    begin
      pstate <= next_pstate;
      if (pstate == SGC_ARMED && frame_start)
        pulse_left <= SGC_PULSE_FRAMES;
      else if (pulse_on && frame_start)
        pulse_left <= pulse_left - 3'h1;
    end
  end

  // outputs
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stop_go_output  <= 1'b0;
      d_channel_block <= 1'b0;
      d_up_out        <= 1'b1;
    end
    else
    begin
      stop_go_output  <= next_sg;
      d_channel_block <= next_block;
      d_up_out        <= d_up_in && !d_channel_block;
    end
  end

  sequence s_pulse_cfg;
    enabled && burst_select && !level_select;
  endsequence

  sequence s_last_frame;
    pulse_on && frame_start && pulse_left == SGC_PULSE_LAST;
  endsequence

  property p_pulse_high;
    @(posedge clk_sys) disable iff (sys_rst)
    (s_pulse_cfg ##0 (pulse_on && !polarity_select)) |=> stop_go_output;
  endproperty
  a_pulse_high: assert property (p_pulse_high) else $error("pulse not high");

  property p_pulse_low;
    @(posedge clk_sys) disable iff (sys_rst)
    (s_pulse_cfg ##0 (pulse_on && polarity_select)) |=> !stop_go_output;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("inverted pulse not low");

  property p_const_level;
    @(posedge clk_sys) disable iff (sys_rst)
    (enabled && !burst_select && !(level_select && polarity_select))
      |=> (stop_go_output == $past(level_select));
  endproperty
  a_const_level: assert property (p_const_level) else $error("constant level wrong");

  property p_stop_sets;
    @(posedge clk_sys) disable iff (sys_rst)
    (stop_ok && mode_latch) |=> latched ##1 stop_go_output;
  endproperty
  a_stop_sets: assert property (p_stop_sets) else $error("stop did not set");

  property p_go_clears;
    @(posedge clk_sys) disable iff (sys_rst)
    (go_ok && !stop_ok && mode_latch) |=> !latched;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("go did not clear");

  property p_bac_no_block;
    @(posedge clk_sys) disable iff (sys_rst)
    (!burst_select) |=> !d_channel_block ##1 (d_up_out == $past(d_up_in));
  endproperty
  a_bac_no_block: assert property (p_bac_no_block) else $error("d channel blocked");

  property p_bac_ignored;
    @(posedge clk_sys) disable iff (sys_rst)
    (enabled && burst_select && level_select && !polarity_select)
      |=> (stop_go_output == $past(latched)) && !d_channel_block;
  endproperty
  a_bac_ignored: assert property (p_bac_ignored) else $error("access bit not ignored");

  property p_bac_gates;
    @(posedge clk_sys) disable iff (sys_rst)
    (enabled && burst_select && level_select && polarity_select && !bac)
      |=> d_channel_block && stop_go_output ##1 !d_up_out;
  endproperty
  a_bac_gates: assert property (p_bac_gates) else $error("access bit not gating");

  property p_reset_pol;
    @(posedge clk_sys) disable iff (sys_rst)
    $past(sys_rst) |-> !polarity_select;
  endproperty
  a_reset_pol: assert property (p_reset_pol) else $error("polarity not cleared");

  property p_pulse_end;
    @(posedge clk_sys) disable iff (sys_rst)
    s_last_frame |=> (pstate == SGC_IDLE);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse overran");

  property p_sg_slot;
    @(posedge clk_sys) disable iff (sys_rst)
    (dcl_rise && !frame_start && bit_ctr == SGC_SG_BIT_NUM)
      |=> !bus_dout_oe_n && (bus_dout == $past(stop_go_output));
  endproperty
  a_sg_slot: assert property (p_sg_slot) else $error("stop/go bit not driven");

endmodule : sgc_stop_go_ctrl

/* verif/sgc_far_model.sv */
`timescale 1ns/100ps
module sgc_far_model #(
  parameter int FB = 32
)
(
  input  wire logic bus_dout,
  input  wire logic bus_dout_oe_n,
  input  wire logic access,
  output logic      bus_fsc,
  output logic      bus_dcl,
  output logic      bus_din,
  output logic      sg_seen,
  output logic      sg_drv
);
  // pulled-up open-drain line
  wire logic line = bus_dout_oe_n ? 1'b1 : bus_dout;

  initial
  begin
    bus_fsc = 1'b0;
    bus_dcl = 1'b0;
    bus_din = 1'b1;
    sg_seen = 1'b0;
    sg_drv = 1'b0;
    #7;
    forever
      for (int b = 0; b < FB; b++)
      begin
        bus_fsc = (b == 0);
        // toggling filler, access bit in its slot
        bus_din = (b == 27) ? access : ~bus_din;
        #50 bus_dcl = 1'b1;
        #100 bus_dcl = 1'b0;
        if (b == 27)
        begin
          sg_seen = line;
          sg_drv = ~bus_dout_oe_n;
        end
        #50;
      end
  end
endmodule : sgc_far_model

/* verif/testbench.sv */
`timescale 1ns/100ps
module testbench
  import sgc_pkg::*;
;
  localparam int FB = 32;
  localparam int PC = 4 * FB * 8;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pm = 1'b1;
  logic tm = 1'b1;
  logic rs = 1'b1;
  logic acc = 1'b1;
  logic d_up_in = 1'b1;
  logic [7:0] eoc_code = 8'h00;
  logic eoc_valid = 1'b0;
  logic [3:0] eoc_frame_pos = 4'h0;
  logic fsc, dcl, din, dout, dout_oe_n, d_up_out, sg, blk, sg_seen, sg_drv;
  logic [7:0] v;
  int err_count = 0;
  int total_checks = 0;
  int n;

  always #12.5 clk_sys = ~clk_sys;

  sgc_stop_go_ctrl #(.SHORT_CYC(20), .DELAY_MIN_CYC(50), .DELAY_STEP_CYC(5)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .processor_mode_input(pm),
    .terminal_mode_input(tm), .receiver_synchronised(rs), .eoc_code(eoc_code),
    .eoc_valid(eoc_valid), .eoc_frame_pos(eoc_frame_pos), .bus_fsc(fsc), .bus_dcl(dcl),
    .bus_din(din), .bus_dout(dout), .bus_dout_oe_n(dout_oe_n), .d_up_in(d_up_in),
    .d_up_out(d_up_out), .stop_go_output(sg), .d_channel_block(blk));

  sgc_far_model #(.FB(FB)) far (
    .bus_dout(dout), .bus_dout_oe_n(dout_oe_n), .access(acc), .bus_fsc(fsc),
    .bus_dcl(dcl), .bus_din(din), .sg_seen(sg_seen), .sg_drv(sg_drv));

  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : rd

  // mode bits: polarity, level, burst
  task mode(input logic [2:0] m);
    wr(4'h0, {5'h00, m});
    cyc(6);
  endtask : mode

  task code(input logic [7:0] c);
    @(posedge clk_sys);
    eoc_code <= c;
    eoc_valid <= 1'b1;
    @(posedge clk_sys);
    eoc_valid <= 1'b0;
    cyc(6);
  endtask : code

  task t_reset;
    rd(4'h0, v);
    chk(v, SGC_CTRL_RESET, "ctrl reset");
    rd(4'h5, v);
    chk(v, SGC_RD_NONE, "unmapped read");
    chk(sg, 1'b0, "idle stop/go");
  endtask : t_reset

  task t_const;
    logic [2:0] ms [3];
    logic ex [3];
    ms = '{3'h0, 3'h4, 3'h2};
    ex = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++)
    begin
      mode(ms[i]);
      code(SGC_EOC_STOP);
      chk(sg, ex[i], "constant mode");
    end
  endtask : t_const

  task t_pulse(input logic pol);
    mode({pol, 2'b01});
    chk(sg, pol, "pulse idle");
    @(posedge fsc);
    cyc(20);
    code(SGC_EOC_STOP);
    rd(4'h1, v);
    chk(v[SGC_ST_SHORT], 1'b1, "short timer");
    n = 0;
    while (sg === pol && n < 2000)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (sg !== pol && n < 2000)
    begin
      cyc(1);
      n++;
      if (n == 300)
        chk({sg_drv, sg_seen}, {1'b1, ~pol}, "wire bit");
    end
    chk(n >= PC - 4 && n <= PC + 4, 1'b1, "pulse length");
  endtask : t_pulse

  task t_level;
    logic [2:0] ms [3];
    ms = '{3'h3, 3'h6, 3'h7};
    for (int i = 0; i < 3; i++)
    begin
      mode(ms[i]);
      code(SGC_EOC_STOP);
      chk(sg, 1'b1, "stop latches");
      code(SGC_EOC_GO);
      chk(sg, 1'b0, "go clears");
    end
  endtask : t_level

  task t_access;
    acc <= 1'b0;
    cyc(600);
    rd(4'h1, v);
    chk(v[SGC_ST_BAC], 1'b0, "access sampled");
    mode(3'h6);
    chk({sg, blk, d_up_out}, {2'b10, d_up_in}, "access, no gate");
    d_up_in <= 1'b0;
    cyc(2);
    chk(d_up_out, 1'b0, "d channel passed");
    d_up_in <= 1'b1;
    mode(3'h7);
    chk({sg, blk, d_up_out}, 3'b110, "access gates d");
    mode(3'h3);
    chk({sg, blk}, 2'b00, "access ignored");
    acc <= 1'b1;
    cyc(600);
  endtask : t_access

  task t_gate;
    rs <= 1'b0;
    code(SGC_EOC_STOP);
    chk(sg, 1'b0, "unsynced stop");
    rs <= 1'b1;
    mode(3'h2);
    tm <= 1'b0;
    cyc(6);
    chk(sg, 1'b0, "not terminal");
    tm <= 1'b1;
    pm <= 1'b0;
    cyc(8);
    chk(sg, 1'b0, "not processor");
    pm <= 1'b1;
    cyc(8);
    chk(sg, 1'b1, "enabled again");
  endtask : t_gate

  task t_delay;
    mode(3'h3);
    eoc_frame_pos <= 4'h2;
    code(SGC_EOC_STOP);
    rs <= 1'b0;
    cyc(40);
    chk(sg, 1'b1, "delay holds");
    rd(4'h1, v);
    chk(v[SGC_ST_DELAY], 1'b1, "delay running");
    // length 50 + 2 * 5 cycles: a shorter timer would already have cleared
    cyc(16);
    chk(sg, 1'b1, "delay length");
    cyc(8);
    chk(sg, 1'b0, "delay expired");
    rs <= 1'b1;
  endtask : t_delay

  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial
  begin
    #1000000;
    err_count++;
    end_of_test;
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(8);
    t_reset;
    t_const;
    t_pulse(1'b0);
    t_pulse(1'b1);
    t_level;
    t_access;
    t_gate;
    t_delay;
    end_of_test;
  end
endmodule : testbench
